// ==== rtl/cip_pkg.sv ====
// Package: register map, field layout and reset values of the interrupt prioritizer
package cip_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int CIP_NCH = 32;
    localparam int CIP_IDXW = 6;
    // No-interrupt vector value: bit 5 set, never a channel number
    localparam logic [5:0] CIP_NO_VECTOR = 6'h3f;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CIP_OFF_MASK = 8'h00;
    localparam logic [7:0] CIP_OFF_LEVEL = 8'h04;
    localparam logic [7:0] CIP_OFF_PEND = 8'h08;
    localparam logic [7:0] CIP_OFF_FAST_VEC = 8'h0c;
    localparam logic [7:0] CIP_OFF_NORM_VEC = 8'h10;
    localparam logic [7:0] CIP_OFF_SWREQ = 8'h14;
    localparam logic [7:0] CIP_OFF_SAG_STAT = 8'h18;
    localparam logic [7:0] CIP_OFF_EVT_STAT = 8'h1c;
    localparam logic [7:0] CIP_OFF_EVT_CLR = 8'h20;
    localparam logic [7:0] CIP_OFF_EVT_EN = 8'h24;

    // ------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------
    localparam logic [31:0] CIP_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] CIP_LEVEL_RST = 32'h0000_0000;
    localparam logic [1:0] CIP_RESP_OKAY = 2'h0;
    localparam logic [1:0] CIP_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Channel numbers of fixed sources
    // ------------------------------------------------------------
    localparam int CIP_CH_SAG = 0;
    localparam int CIP_CH_PIN = 1;
    localparam int CIP_CH_WD_EXP = 2;
    localparam int CIP_CH_WD_HALF = 3;
    localparam int CIP_CH_SER_ERR = 4;
    localparam int CIP_CH_SER0_RX = 5;
    localparam int CIP_CH_SER0_TX = 6;
    localparam int CIP_CH_SER1_RX = 7;
    localparam int CIP_CH_SER1_TX = 8;
    localparam int CIP_CH_PMBUS = 9;
    localparam int CIP_CH_CMP_SER = 10;
    localparam int CIP_CH_SW = 31;

    // Event status bits
    localparam int CIP_EV_FAST = 0;
    localparam int CIP_EV_NORM = 1;
    localparam int CIP_EV_SAG = 2;
    localparam int CIP_NEV = 3;
endpackage

// ==== rtl/cip_prio_enc.sv ====
// Fixed-precedence encoder: highest set bit wins
`timescale 1ns/1ps
module cip_prio_enc
    import cip_pkg::*;
#(
    parameter int NCH = 32
) (
    input wire logic [NCH-1:0] req,
    output logic [5:0] index,
    output logic any
);
    // ------------------------------------------------------------
    // Scan upward so the highest channel overrides
    // ------------------------------------------------------------
    always_comb begin
        index = CIP_NO_VECTOR;
        any = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (req[i]) begin
                index = 6'(i);
                any = 1'b1;
            end
        end
    end
endmodule

// ==== rtl/cip_top.sv ====
// Central interrupt prioritizer: request mapping, masking, levels, vectors, AXI4-Lite slave
// ------------------------------------------------------------
// Overview of operation
// - Thirty-two independent request channels, numbered 0 to 31.
// - Fast and normal interrupt outputs; fast takes priority over normal.
// - Each level shows the vector index of its highest unmasked pending channel.
// - Precedence fixed by number; channel 31 highest, channel 0 lowest.
// - Per-channel mask; masked channel drives neither level output and no vector.
// - Supply sag sets a status bit and requests channel 0.
// - External pin request goes to channel 1.
// - Watchdog expiry request goes to channel 2.
// - Watchdog halfway wake-up request goes to channel 3.
// - Errors from both serial ports share channel 4.
// - Serial port 0 receive on channel 5, transmit empty on 6.
// - Serial port 1 receive on channel 7, transmit empty on 8.
// - PMBus request goes to channel 9.
// - Comparator, SPI and I2C requests combine onto channel 10.
// - Channel 31 is the software request; 11 to 30 other sources.
// ------------------------------------------------------------
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module cip_top
    import cip_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supply_sag_request,
    input wire logic pin_event_request,
    input wire logic watchdog_expiry_request,
    input wire logic watchdog_halfway_request,
    input wire logic serial0_error_request,
    input wire logic serial1_error_request,
    input wire logic serial0_receive_request,
    input wire logic serial0_transmit_request,
    input wire logic serial1_receive_request,
    input wire logic serial1_transmit_request,
    input wire logic pmbus_request,
    input wire logic comparator_request,
    input wire logic spi_request,
    input wire logic i2c_request,
    input wire logic [19:0] upper_requests,
    output logic fast_interrupt_level,
    output logic normal_interrupt_level,
    output logic event_irq
);
    // ------------------------------------------------------------
    // Input synchronisers: all external sources are treated as asynchronous
    // ------------------------------------------------------------
    logic [CIP_NCH-1:0] raw_req;
    logic [CIP_NCH-1:0] sync1;
    logic [CIP_NCH-1:0] pending;
    logic [CIP_NCH-1:0] sw_req;
    logic [CIP_NCH-1:0] mask_en;
    logic [CIP_NCH-1:0] level_fast;
    logic [CIP_NCH-1:0] next_mask_en;
    logic [CIP_NCH-1:0] next_level_fast;
    logic [CIP_NCH-1:0] next_sw_req;

    // Fixed source-to-channel map; level sources, held until removed
    always_comb begin
        raw_req = {CIP_NCH{1'b0}};
        raw_req[CIP_CH_SAG] = supply_sag_request;
        raw_req[CIP_CH_PIN] = pin_event_request;
        raw_req[CIP_CH_WD_EXP] = watchdog_expiry_request;
        raw_req[CIP_CH_WD_HALF] = watchdog_halfway_request;
        raw_req[CIP_CH_SER_ERR] = serial0_error_request | serial1_error_request;
        raw_req[CIP_CH_SER0_RX] = serial0_receive_request;
        raw_req[CIP_CH_SER0_TX] = serial0_transmit_request;
        raw_req[CIP_CH_SER1_RX] = serial1_receive_request;
        raw_req[CIP_CH_SER1_TX] = serial1_transmit_request;
        raw_req[CIP_CH_PMBUS] = pmbus_request;
        raw_req[CIP_CH_CMP_SER] = comparator_request | spi_request | i2c_request;
        raw_req[CIP_CH_SW-1:CIP_CH_CMP_SER+1] = upper_requests;
    end

    // Two flops; software channel bypasses since it is already in this domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            pending <= '0;
        end else begin
            sync1 <= raw_req;
            pending <= sync1 | sw_req;
        end
    end

    // ------------------------------------------------------------
    // Masking, level split and ranking
    // ------------------------------------------------------------
    logic [CIP_NCH-1:0] active;
    logic [CIP_NCH-1:0] fast_set;
    logic [CIP_NCH-1:0] norm_set;
    logic [5:0] fast_idx;
    logic [5:0] norm_idx;
    logic fast_any;
    logic norm_any;

    assign active = pending & mask_en;
    assign fast_set = active & level_fast;
    assign norm_set = active & ~level_fast;

    cip_prio_enc #(.NCH(CIP_NCH)) u_fast_enc (
        .req(fast_set),
        .index(fast_idx),
        .any(fast_any)
    );
    cip_prio_enc #(.NCH(CIP_NCH)) u_norm_enc (
        .req(norm_set),
        .index(norm_idx),
        .any(norm_any)
    );

    // Registered outputs and vectors; fast line overrides normal at the core
    logic fast_q;
    logic norm_q;
    logic [5:0] fast_vec;
    logic [5:0] norm_vec;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_q <= 1'b0;
            norm_q <= 1'b0;
            fast_vec <= CIP_NO_VECTOR;
            norm_vec <= CIP_NO_VECTOR;
        end else begin
            fast_q <= fast_any;
            norm_q <= norm_any;
            fast_vec <= fast_idx;
            norm_vec <= norm_idx;
        end
    end
    assign fast_interrupt_level = fast_q;
    assign normal_interrupt_level = norm_q;

    // ------------------------------------------------------------
    // Sticky events: fast/normal assertion and supply sag
    // ------------------------------------------------------------
    logic [CIP_NEV-1:0] evt_stat;
    logic [CIP_NEV-1:0] evt_en;
    logic [CIP_NEV-1:0] next_evt_stat;
    logic [CIP_NEV-1:0] next_evt_en;
    logic [CIP_NEV-1:0] evt_hit;
    logic [CIP_NEV-1:0] evt_clr;
    logic sag_seen;
    logic next_sag_seen;
    logic sag_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sag_prev <= 1'b0;
        end else begin
            sag_prev <= pending[CIP_CH_SAG];
        end
    end

    always_comb begin
        evt_hit = '0;
        evt_hit[CIP_EV_FAST] = fast_any & ~fast_q;
        evt_hit[CIP_EV_NORM] = norm_any & ~norm_q;
        evt_hit[CIP_EV_SAG] = pending[CIP_CH_SAG] & ~sag_prev;
        // Set wins over a same-cycle clear
        next_evt_stat = (evt_stat & ~evt_clr) | evt_hit;
    end
    assign event_irq = |(evt_stat & evt_en);

    // ------------------------------------------------------------
    // AXI4-Lite slave: one write and one read outstanding
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;

    // Byte-lane merge, reused by the mask, level and software request registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = ~aw_held & ~bvalid_q;
    assign s_axi_wready = ~w_held & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign do_write = aw_held & w_held & ~bvalid_q;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid_q;
        next_bresp = bresp_q;
        next_rvalid = rvalid_q;
        next_rdata = rdata_q;
        next_rresp = rresp_q;
        next_mask_en = mask_en;
        next_level_fast = level_fast;
        next_sw_req = sw_req;
        next_evt_en = evt_en;
        evt_clr = '0;
        next_sag_seen = sag_seen | evt_hit[CIP_EV_SAG];
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = CIP_RESP_OKAY;
            case (aw_addr)
                CIP_OFF_MASK: next_mask_en = lane_merge(mask_en, w_data, w_strb);
                CIP_OFF_LEVEL: next_level_fast = lane_merge(level_fast, w_data, w_strb);
                CIP_OFF_SWREQ: next_sw_req = lane_merge(sw_req, w_data, w_strb) & (32'h1 << CIP_CH_SW);
                CIP_OFF_SAG_STAT: next_sag_seen = sag_seen & ~(w_strb[0] & w_data[0]);
                CIP_OFF_EVT_CLR: evt_clr = w_strb[0] ? w_data[CIP_NEV-1:0] : '0;
                CIP_OFF_EVT_EN: next_evt_en = w_strb[0] ? w_data[CIP_NEV-1:0] : evt_en;
                CIP_OFF_PEND, CIP_OFF_FAST_VEC, CIP_OFF_NORM_VEC, CIP_OFF_EVT_STAT: begin
                    next_bresp = CIP_RESP_OKAY;
                end
                default: next_bresp = CIP_RESP_SLVERR;
            endcase
            if (aw_addr == CIP_OFF_SAG_STAT && evt_hit[CIP_EV_SAG]) begin
                next_sag_seen = 1'b1;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rvalid_q && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = CIP_RESP_OKAY;
            next_rdata = '0;
            case (s_axi_araddr[7:0])
                CIP_OFF_MASK: next_rdata = mask_en;
                CIP_OFF_LEVEL: next_rdata = level_fast;
                CIP_OFF_PEND: next_rdata = pending;
                CIP_OFF_FAST_VEC: next_rdata = {26'h0, fast_vec};
                CIP_OFF_NORM_VEC: next_rdata = {26'h0, norm_vec};
                CIP_OFF_SWREQ: next_rdata = sw_req;
                CIP_OFF_SAG_STAT: next_rdata = {31'h0, sag_seen};
                CIP_OFF_EVT_STAT: next_rdata = {29'h0, evt_stat};
                CIP_OFF_EVT_CLR: next_rdata = '0;
                CIP_OFF_EVT_EN: next_rdata = {29'h0, evt_en};
                default: next_rresp = CIP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= CIP_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= CIP_RESP_OKAY;
            mask_en <= CIP_MASK_RST;
            level_fast <= CIP_LEVEL_RST;
            sw_req <= '0;
            evt_stat <= '0;
            evt_en <= '0;
            sag_seen <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid_q <= next_bvalid;
            bresp_q <= next_bresp;
            rvalid_q <= next_rvalid;
            rdata_q <= next_rdata;
            rresp_q <= next_rresp;
            mask_en <= next_mask_en;
            level_fast <= next_level_fast;
            sw_req <= next_sw_req;
            evt_stat <= next_evt_stat;
            evt_en <= next_evt_en;
            sag_seen <= next_sag_seen;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_fast_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (|fast_set) |=> fast_interrupt_level) else $error("fast line missed");
    chk_norm_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (|norm_set) |=> normal_interrupt_level) else $error("normal line missed");
    chk_fast_vec_top: assert property (@(posedge aclk) disable iff (!aresetn)
        (|fast_set) |=> (fast_vec < 6'd32)
        && (($past(fast_set) >> fast_vec[4:0]) == 32'h1)) else $error("fast vector wrong");
    chk_norm_vec_top: assert property (@(posedge aclk) disable iff (!aresetn)
        (|norm_set) |=> (($past(norm_set) >> norm_vec[4:0]) == 32'h1)) else $error("normal vector wrong");
    chk_masked_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (mask_en == 32'h0) |=> !fast_interrupt_level && !normal_interrupt_level) else $error("masked fired");
    chk_idle_vector: assert property (@(posedge aclk) disable iff (!aresetn)
        (active == 32'h0) |=> (fast_vec == CIP_NO_VECTOR) && (norm_vec == CIP_NO_VECTOR))
        else $error("idle vector wrong");
    sequence sag_rise_s;
        supply_sag_request ##1 supply_sag_request ##1 supply_sag_request;
    endsequence
    chk_sag_channel: assert property (@(posedge aclk) disable iff (!aresetn)
        sag_rise_s |=> pending[CIP_CH_SAG]) else $error("sag not on channel 0");
    chk_pin_channel: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_event_request [*3] |=> pending[CIP_CH_PIN]) else $error("pin not on channel 1");
    chk_level_reset: assert property (@(posedge aclk)
        !aresetn |=> (level_fast == 32'h0) && (mask_en == 32'h0)) else $error("reset state wrong");
endmodule

// ==== dv/cip_core_model.sv ====
// Processor core model: samples both interrupt lines and services the fast one first
`timescale 1ns/1ps
module cip_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fast_interrupt_level,
    input wire logic normal_interrupt_level,
    output logic [1:0] grant
);
    logic [1:0] next_grant;

    // Fast line wins whenever both are raised; 2 fast, 1 normal, 0 idle
    always_comb begin
        next_grant = 2'h0;
        if (fast_interrupt_level) begin
            next_grant = 2'h2;
        end else if (normal_interrupt_level) begin
            next_grant = 2'h1;
        end
    end

    // Registered like a real core's interrupt sampling stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grant <= 2'h0;
        end else begin
            grant <= next_grant;
        end
    end
endmodule

// ==== dv/central_interrupt_prioritizer_tb.sv ====
// Self-checking testbench of the interrupt prioritizer
`timescale 1ns/1ps
module central_interrupt_prioritizer_tb;
    import cip_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rnd = 32'ha2c01c16, m, l, p;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, fast, norm, evirq;
    logic [1:0] bresp, rresp, grant;
    logic [3:0] wstrb = 4'hf;
    logic [33:0] src = 34'h0; // Every request input, in port order
    logic [34:0] exp_r[$];
    logic [34:0] er;
    logic [1:0] exp_b[$];
    int fails = 0, samples_checked = 0, s;

    cip_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_sag_request(src[0]),
        .pin_event_request(src[1]), .watchdog_expiry_request(src[2]), .watchdog_halfway_request(src[3]),
        .serial0_error_request(src[4]), .serial1_error_request(src[5]), .serial0_receive_request(src[6]),
        .serial0_transmit_request(src[7]), .serial1_receive_request(src[8]),
        .serial1_transmit_request(src[9]), .pmbus_request(src[10]), .comparator_request(src[11]),
        .spi_request(src[12]), .i2c_request(src[13]), .upper_requests(src[33:14]),
        .fast_interrupt_level(fast), .normal_interrupt_level(norm), .event_irq(evirq));

    cip_core_model core (.aclk(aclk), .aresetn(aresetn), .fast_interrupt_level(fast),
        .normal_interrupt_level(norm), .grant(grant));

    initial begin
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Highest set bit, or the no-interrupt code when nothing is set
    function automatic logic [31:0] hb(input logic [31:0] v);
        hb = {26'h0, CIP_NO_VECTOR};
        for (int i = 0; i < 32; i++)
            if (v[i]) hb = 32'(i);
    endfunction

    // Source bit to channel: both serial errors share 4, three sources share 10
    function automatic int chmap(input int k);
        if (k < 5) return k;
        if (k < 11) return k - 1;
        if (k < 14) return 10;
        return k - 3;
    endfunction

    task automatic end_sim;
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    // Bus master: both write channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CIP_RESP_OKAY);
        int n;
        exp_b.push_back(r);
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) begin
            fails++;
            end_sim();
        end
    endtask

    // Read; data compare can be skipped where only the response code is defined
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [2:0] r = 3'h4);
        int n;
        exp_r.push_back({r, d});
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) begin
            fails++;
            end_sim();
        end
    endtask

    // Monitor: oldest expected answer against each completed response
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            er = exp_r.pop_front();
            cmp("rresp", 32'(er[33:32]), 32'(rresp));
            if (er[34]) cmp("rdata", er[31:0], rdata);
        end
        if (bvalid && bready) cmp("bresp", 32'(exp_b.pop_front()), 32'(bresp));
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CIP_OFF_MASK, CIP_MASK_RST);
        rd(CIP_OFF_LEVEL, CIP_LEVEL_RST);
        rd(CIP_OFF_FAST_VEC, hb(32'h0));
        // Masked channel is pending but stays silent
        src <= 34'h2_0000_0000;
        repeat (5) @(posedge aclk);
        cmp("normal masked", 32'h0, 32'(norm));
        rd(CIP_OFF_PEND, 32'h4000_0000);
        rd(CIP_OFF_NORM_VEC, hb(32'h0));
        src <= 34'h0;
        wr(CIP_OFF_MASK, 32'hffff_ffff);
        // Each source alone reaches its own channel on the normal line
        for (s = 0; s < 34; s++) begin
            src <= 34'h1 << s;
            repeat (5) @(posedge aclk);
            cmp("normal", 32'h1, 32'(norm));
            cmp("grant", 32'h1, 32'(grant));
            rd(CIP_OFF_NORM_VEC, 32'(chmap(s)));
            src <= 34'h0;
            repeat (5) @(posedge aclk);
            cmp("normal idle", 32'h0, 32'(norm));
        end
        // Byte lane 1 alone clears channels 8 to 15 of the mask
        wstrb <= 4'h2;
        wr(CIP_OFF_MASK, 32'h0);
        wstrb <= 4'hf;
        rd(CIP_OFF_MASK, 32'hffff00ff);
        // Sticky status, enable and clear
        rd(CIP_OFF_EVT_STAT, 32'h6);
        rd(CIP_OFF_SAG_STAT, 32'h1);
        wr(CIP_OFF_SAG_STAT, 32'h1);
        rd(CIP_OFF_SAG_STAT, 32'h0);
        cmp("event_irq", 32'h0, 32'(evirq));
        wr(CIP_OFF_EVT_EN, 32'h4);
        @(posedge aclk);
        cmp("event_irq", 32'h1, 32'(evirq));
        wr(CIP_OFF_EVT_CLR, 32'h4);
        @(posedge aclk);
        cmp("event_irq", 32'h0, 32'(evirq));
        rd(CIP_OFF_EVT_STAT, 32'h2);
        rd(CIP_OFF_EVT_CLR, 32'h0);
        wr(8'h40, 32'h1, CIP_RESP_SLVERR);
        rd(8'h40, 32'h0, {1'b0, CIP_RESP_SLVERR});
        // Random masks, levels and requests, software channel included
        repeat (24) begin
            rnd = xs(rnd);
            m = rnd;
            rnd = xs(rnd);
            l = rnd;
            rnd = xs(rnd);
            p = {rnd[31:11], 11'h0};
            src <= {p[30:11], 14'h0};
            wr(CIP_OFF_MASK, m);
            wr(CIP_OFF_LEVEL, l);
            wr(CIP_OFF_SWREQ, {p[31], 31'h0});
            repeat (5) @(posedge aclk);
            cmp("fast", 32'(|(p & m & l)), 32'(fast));
            cmp("normal", 32'(|(p & m & ~l)), 32'(norm));
            cmp("grant", (|(p & m & l)) ? 32'h2 : 32'(|(p & m)), 32'(grant));
            rd(CIP_OFF_PEND, p);
            rd(CIP_OFF_FAST_VEC, hb(p & m & l));
            rd(CIP_OFF_NORM_VEC, hb(p & m & ~l));
        end
        end_sim();
    end
endmodule
